// ==== testbench/art_serial_station.sv ====
// Remote serial station model: x16 bit clocks, word sender and word decoder
module art_serial_station (
  input wire logic clk,
  input wire logic txLine,
  output logic rxClk,
  output logic txClk,
  output logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  int div = 0;
  //////////////////////////////////////////////////////////////////////////////
  // Bit clocks; halves of 4 and 5 cycles so the device never misses an edge
  initial begin
    rxClk = 1'b0;
    txClk = 1'b0;
    line = 1'b1;
  end
  always @(negedge clk) begin
    div <= div + 1;
    if (div % 4 == 3) rxClk <= ~rxClk;
    if (div % 5 == 4) txClk <= ~txClk;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Word sender, 16 ticks a bit; par below zero means no parity bit
  task automatic sendWord(input logic [7:0] d, input int nb, input int par,
    input logic stopBit);
    line = 1'b0;
    repeat (16) @(posedge rxClk);
    for (int k = 0; k <= nb; k++) begin
      // Parity slot is skipped entirely when no parity bit is sent
      if (k < nb || par >= 0) begin
        line = (k < nb) ? d[k] : par[0];
        repeat (16) @(posedge rxClk);
      end
    end
    line = stopBit;
    repeat (16) @(posedge rxClk);
    line = 1'b1;
  endtask
  // Short low pulse that must not pass for a start bit
  task automatic glitch(input int n);
    line = 1'b0;
    repeat (n) @(posedge rxClk);
    line = 1'b1;
  endtask
  // Decoder samples each bit at its centre
  task automatic recvWord(input int nb, input bit hasPar,
    output logic [7:0] d, output logic pb, output logic sb, output logic st);
    d = '0;
    pb = 1'b0;
    @(negedge txLine);
    repeat (8) @(posedge txClk);
    st = txLine;
    for (int k = 0; k < nb + int'(hasPar); k++) begin
      repeat (16) @(posedge txClk);
      if (k < nb) d[k] = txLine;
      else pb = txLine;
    end
    repeat (16) @(posedge txClk);
    sb = txLine;
  endtask
endmodule

// ==== testbench/test_async_receiver_transmitter.sv ====
// Self-checking bench of the async receiver/transmitter
module test_async_receiver_transmitter;
  timeunit 1ns;
  timeprecision 100ps;
  import art_pkg::*;
  logic clk, srst, masterClear, rxClk, txClk, line, loadN, drClrN, cfgLd;
  logic rxTri, flTri, rxOe, flOe, txLine, txEmpty;
  logic [7:0] txData, rxOut, mask, dA, dB, dR;
  art_cfg_t cfg;
  art_flags_t flags;
  int nFail = 0;
  int numChecks = 0;
  int nb, pm, two, stopT, t, drM;
  //////////////////////////////////////////////////////////////////////////////
  // Clock, device and far station
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  art_uart i_dut (.clk(clk), .srst(srst), .masterClear(masterClear),
    .rxBitClockX16(rxClk), .txBitClockX16(txClk), .receiveLineIn(line),
    .txBufferLoadStrobeN(loadN), .txParallelIn(txData),
    .dataReadyClearN(drClrN), .configLatch(cfgLd), .cfgIn(cfg),
    .rxDataTristate(rxTri), .flagsTristate(flTri), .rxParallelOut(rxOut),
    .rxParallelOe(rxOe), .flagsOut(flags), .flagsOe(flOe),
    .txLineOut(txLine), .txShiftEmpty(txEmpty));
  art_serial_station i_station (.clk(clk), .txLine(txLine), .rxClk(rxClk),
    .txClk(txClk), .line(line));
  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Parity bit that makes the ones count even, or odd when even is low
  function automatic logic parOf(logic [7:0] d, logic even);
    return even ? ^d : ~^d;
  endfunction
  // Strobe low loads the holding register; the rise asks for the move
  task automatic load(input logic [7:0] d);
    txData = d;
    loadN = 1'b0;
    cyc(4);
    check("buffer empty", flags.txBufEmpty, 0);
    loadN = 1'b1;
  endtask
  task automatic takeWord(input logic [7:0] d);
    logic [7:0] gd;
    logic gp, gs, gst;
    i_station.recvWord(nb, pm != 2, gd, gp, gs, gst);
    check("tx start", gst, 0);
    check("tx data", gd, d & mask);
    if (pm != 2) check("tx parity", gp, parOf(d & mask, pm == 0));
    check("tx stop", gs, 1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Hang guard, well beyond the expected run of about 27k cycles
  initial begin
    repeat (80000) @(posedge clk);
    nFail++;
    stopTest();
  end
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {srst, masterClear, loadN, drClrN, cfgLd, rxTri, flTri} = 7'h58;
    txData = 8'h00;
    cfg = '0;
    drM = 0;
    void'($urandom(32'h66f35187));
    cyc(2);
    srst = 1'b0;
    cyc(3);
    check("idle line", txLine, 1);
    check("idle shift", txEmpty, 1);
    // Every length, parity mode and stop count, both directions at once
    for (int i = 0; i < 8; i++) begin
      nb = 5 + i % 4;
      pm = i % 3;
      two = i / 4;
      mask = 8'hff >> (8 - nb);
      stopT = two ? (nb == 5 ? 24 : 32) : 16;
      cfg = '{lenSel: 2'(i % 4), evenPar: pm == 0, parDis: pm == 2,
        twoStop: two[0]};
      cfgLd = 1'b1;
      cyc(4);
      cfgLd = 1'b0;
      dA = 8'($urandom);
      dB = 8'($urandom);
      dR = 8'($urandom);
      fork
        begin
          takeWord(dA);
          takeWord(dB);
          t = 0;
          while (txEmpty !== 1'b1 && t < 60) begin
            @(posedge txClk);
            t++;
          end
          check("stop ticks", t >= stopT - 10 && t <= stopT - 6, 1);
        end
        begin
          load(dA);
          cyc(4);
          check("buffer freed", flags.txBufEmpty, 1);
          load(dB);
          check("shift busy", txEmpty, 0);
        end
        i_station.sendWord(dR, nb, pm == 2 ? -1 :
          int'(parOf(dR & mask, pm == 0) ^ (i == 3)), i != 5);
      join
      cyc(2);
      check("rx data", rxOut, dR & mask);
      check("parity error", flags.parityErr, pm != 2 && i == 3);
      check("framing error", flags.framingErr, i == 5);
      check("overrun", flags.overrun, drM);
      check("data received", flags.dataReceived, 1);
      drM = 1;
      if (i % 2 == 0) begin
        drClrN = 1'b0;
        cyc(4);
        drClrN = 1'b1;
        check("ack", flags.dataReceived, 0);
        drM = 0;
      end
      $display("test %0d done", i);
    end
    // Each disconnect pin releases only its own outputs
    rxTri = 1'b1;
    cyc(4);
    check("rx oe off", rxOe, 0);
    check("flag oe on", flOe, 1);
    rxTri = 1'b0;
    flTri = 1'b1;
    cyc(4);
    check("rx oe on", rxOe, 1);
    check("flag oe off", flOe, 0);
    flTri = 1'b0;
    $display("test tristate done");
    // Master clear in mid-word
    load(8'h5a);
    t = 0;
    while (txLine !== 1'b0 && t < 50) begin
      cyc(1);
      t++;
    end
    check("clr start bit", txLine, 0);
    cyc(30);
    masterClear = 1'b1;
    cyc(5);
    check("clr line", txLine, 1);
    check("clr shift", txEmpty, 1);
    check("clr buffer", flags.txBufEmpty, 1);
    check("clr flags", flags[4:1], 0);
    check("clr holding", rxOut, 0);
    masterClear = 1'b0;
    cyc(5);
    $display("test master clear done");
    // A low pulse shorter than half a bit is not a start bit
    i_station.glitch(4);
    // Wait past a whole word so an accepted false start would show
    repeat (200) @(posedge rxClk);
    check("false start", flags.dataReceived, 0);
    check("false start data", rxOut, 0);
    $display("test false start done");
    stopTest();
  end
endmodule

// ==== verilog/art_pkg.sv ====
// Constants, carrier structs and state types of the async receiver/transmitter
package art_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser vector layout (bit positions of each pin)
  localparam int ART_S_RXCLK = 0;
  localparam int ART_S_TXCLK = 1;
  localparam int ART_S_LINE = 2;
  localparam int ART_S_MCLR = 3;
  localparam int ART_S_LOAD = 4;
  localparam int ART_S_DRCLR = 5;
  localparam int ART_S_CFGLD = 6;
  localparam int ART_S_RXTRI = 7;
  localparam int ART_S_FLTRI = 8;
  localparam int ART_S_CFG = 9;
  localparam int ART_CFG_W = 5;
  localparam int ART_S_DATA = 14;
  localparam int ART_DATA_W = 8;
  localparam int ART_SYNC_W = 22;
  // Idle pin levels (line, load strobe, acknowledge high) seeded at reset so
  // the edge detectors see no false fall or rise once reset is released
  localparam logic [ART_SYNC_W-1:0] ART_SYNC_IDLE = 22'h000034;

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing in x16 clock ticks (count value at the end of an interval)
  localparam logic [4:0] ART_BIT_LAST = 5'h0f;
  localparam logic [4:0] ART_MID_START = 5'h07;
  localparam logic [4:0] ART_STOP1_LAST = 5'h0f;
  localparam logic [4:0] ART_STOP15_LAST = 5'h17;
  localparam logic [4:0] ART_STOP2_LAST = 5'h1f;
  localparam logic [1:0] ART_LEN5 = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [1:0] lenSel;   // Upper select line first
    logic evenPar;
    logic parDis;
    logic twoStop;
  } art_cfg_t;

  typedef struct packed {
    logic parityErr;
    logic framingErr;
    logic overrun;
    logic dataReceived;
    logic txBufEmpty;
  } art_flags_t;

  typedef enum logic [2:0] {
    ART_TX_IDLE, ART_TX_START, ART_TX_DATA, ART_TX_PARITY, ART_TX_STOP
  } art_tx_st_t;

  typedef enum logic [2:0] {
    ART_RX_IDLE, ART_RX_START, ART_RX_DATA, ART_RX_PARITY, ART_RX_STOP
  } art_rx_st_t;

  typedef struct packed {
    logic [ART_SYNC_W-1:0] sync1;
    logic [ART_SYNC_W-1:0] sync2;
    logic rxClkPrev;
    logic txClkPrev;
    logic loadPrev;
    logic linePrev;
    art_cfg_t cfg;
    art_tx_st_t txState;
    logic [4:0] txCnt;
    logic [2:0] txBit;
    logic [7:0] txShift;
    logic [7:0] txHold;
    logic txPend;
    logic txHoldEmpty;
    logic txLine;
    art_rx_st_t rxState;
    logic [4:0] rxCnt;
    logic [2:0] rxBit;
    logic [7:0] rxShift;
    logic rxPar;
    logic [7:0] rxHold;
    logic pe;
    logic fe;
    logic oe;
    logic dr;
  } art_state_t;

  localparam art_state_t ART_STATE_RST = '{
    txState: ART_TX_IDLE,
    rxState: ART_RX_IDLE,
    txHoldEmpty: 1'b1,
    txLine: 1'b1,
    linePrev: 1'b1,
    loadPrev: 1'b1,
    sync1: ART_SYNC_IDLE,
    sync2: ART_SYNC_IDLE,
    default: '0
  };

endpackage

// ==== verilog/art_uart.sv ====
// Pin-programmed asynchronous receiver/transmitter, one clock domain
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Five to eight data bits, both directions
// - One/two stop bits; 1.5 with five bits
// - Parity inhibit disables generation and checking
// - Transmit start, data, parity, stop bits
// - Receive into character, check parity, stop
// - Shift plus holding register each direction
// - Receive data outputs released when tristated
// - Short characters right-justified, upper bits low
// - Parity error updated every transfer
// - Framing error when stop bit low
// - Overrun when data received still set
// - Status flag outputs released when tristated
// - Low data-ready clear resets received flag
// - Received flag set on holding transfer
// - Master clear resets; line and empties high
// - Buffer empty once character moved on
// - Receiver and transmitter run independently
// - Load strobe rise moves character, deferred
// - Even select high even, low odd
module art_uart (
  input wire logic clk,
  input wire logic srst,
  input wire logic masterClear,
  input wire logic rxBitClockX16,
  input wire logic txBitClockX16,
  input wire logic receiveLineIn,
  input wire logic txBufferLoadStrobeN,
  input wire logic [7:0] txParallelIn,
  input wire logic dataReadyClearN,
  input wire logic configLatch,
  input wire art_pkg::art_cfg_t cfgIn,
  input wire logic rxDataTristate,
  input wire logic flagsTristate,
  output logic [7:0] rxParallelOut,
  output logic rxParallelOe,
  output art_pkg::art_flags_t flagsOut,
  output logic flagsOe,
  output logic txLineOut,
  output logic txShiftEmpty
);
  import art_pkg::*;

  art_state_t s_reg;
  art_state_t s_next;
  logic [ART_SYNC_W-1:0] syncIn;
  logic txMove;
  logic rxXfer;

  ////////////////////////////////////////////////////////////////////////////
  // Index of the last data bit for the selected length
  function automatic logic [2:0] lastIdx(input logic [1:0] lenSel);
    lastIdx = {1'b1, lenSel};
  endfunction

  // Parity bit over the used data bits only; excess bits are ignored
  function automatic logic parBit(input logic [7:0] d,
                                  input logic [1:0] lenSel,
                                  input logic evenPar);
    logic [7:0] mask;
    mask = 8'hff >> (3'h7 - lastIdx(lenSel));
    parBit = (^(d & mask)) ^ ~evenPar;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // All pins pass two flops; the x16 clocks are sampled, not used as clocks
  assign syncIn = {txParallelIn, cfgIn, flagsTristate, rxDataTristate,
                   configLatch, dataReadyClearN, txBufferLoadStrobeN,
                   masterClear, receiveLineIn, txBitClockX16, rxBitClockX16};

  // Next-state logic; transmitter and receiver share only configuration and master clear
  always_comb begin
    logic [ART_SYNC_W-1:0] p;
    logic rxTick;
    logic txTick;
    logic line;
    logic txEnd;
    logic txStopEnd;
    logic rxSample;
    logic [4:0] txLimit;
    logic [2:0] txLast;
    logic [2:0] rxLast;
    s_next = s_reg;
    txMove = 1'b0;
    rxXfer = 1'b0;
    p = s_reg.sync2;
    s_next.sync1 = syncIn;
    s_next.sync2 = s_reg.sync1;
    s_next.rxClkPrev = p[ART_S_RXCLK];
    s_next.txClkPrev = p[ART_S_TXCLK];
    s_next.loadPrev = p[ART_S_LOAD];
    s_next.linePrev = p[ART_S_LINE];
    rxTick = p[ART_S_RXCLK] & ~s_reg.rxClkPrev;
    txTick = p[ART_S_TXCLK] & ~s_reg.txClkPrev;
    line = p[ART_S_LINE];
    txLast = lastIdx(s_reg.cfg.lenSel);
    rxLast = lastIdx(s_reg.cfg.lenSel);

    // Control bits follow the pins while the latch input is high
    if (p[ART_S_CFGLD]) begin
      s_next.cfg = art_cfg_t'(p[ART_S_CFG +: ART_CFG_W]);
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmitter bit timing; stop length depends on count and length
    if (s_reg.txState != ART_TX_STOP) begin
      txLimit = ART_BIT_LAST;
    end else if (!s_reg.cfg.twoStop) begin
      txLimit = ART_STOP1_LAST;
    end else if (s_reg.cfg.lenSel == ART_LEN5) begin
      txLimit = ART_STOP15_LAST;
    end else begin
      txLimit = ART_STOP2_LAST;
    end
    txEnd = txTick && (s_reg.txState != ART_TX_IDLE)
            && (s_reg.txCnt == txLimit);
    txStopEnd = txEnd && (s_reg.txState == ART_TX_STOP);
    if (txTick && s_reg.txState != ART_TX_IDLE) begin
      s_next.txCnt = s_reg.txCnt + 5'h01;
    end
    if (txEnd) begin
      s_next.txCnt = 5'h00;
      case (s_reg.txState)
        ART_TX_START: begin
          s_next.txState = ART_TX_DATA;
          s_next.txBit = 3'h0;
          s_next.txLine = s_reg.txShift[0];
        end
        ART_TX_DATA: begin
          if (s_reg.txBit != txLast) begin
            s_next.txBit = s_reg.txBit + 3'h1;
            s_next.txLine = s_reg.txShift[s_reg.txBit + 3'h1];
          end else if (s_reg.cfg.parDis) begin
            s_next.txState = ART_TX_STOP;
            s_next.txLine = 1'b1;
          end else begin
            s_next.txState = ART_TX_PARITY;
            s_next.txLine = parBit(s_reg.txShift, s_reg.cfg.lenSel,
                                   s_reg.cfg.evenPar);
          end
        end
        ART_TX_PARITY: begin
          s_next.txState = ART_TX_STOP;
          s_next.txLine = 1'b1;
        end
        default: begin
          s_next.txState = ART_TX_IDLE;
          s_next.txLine = 1'b1;
        end
      endcase
    end

    // A pending character starts as soon as the shifter is free
    if (s_reg.txPend && (s_reg.txState == ART_TX_IDLE || txStopEnd)) begin
      txMove = 1'b1;
      s_next.txShift = s_reg.txHold;
      s_next.txHoldEmpty = 1'b1;
      s_next.txPend = 1'b0;
      s_next.txState = ART_TX_START;
      s_next.txCnt = 5'h00;
      s_next.txLine = 1'b0;
    end

    // Holding register is transparent while the strobe is low
    if (!p[ART_S_LOAD]) begin
      s_next.txHold = p[ART_S_DATA +: ART_DATA_W];
      s_next.txHoldEmpty = 1'b0;
    end
    if (p[ART_S_LOAD] && !s_reg.loadPrev) begin
      s_next.txPend = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Receiver; the acknowledge is applied first so a new character wins
    if (!p[ART_S_DRCLR]) begin
      s_next.dr = 1'b0;
    end
    rxSample = 1'b0;
    if (s_reg.rxState == ART_RX_IDLE) begin
      if (s_reg.linePrev && !line) begin
        s_next.rxState = ART_RX_START;
        s_next.rxCnt = 5'h00;
        s_next.rxBit = 3'h0;
        s_next.rxShift = 8'h00;
      end
    end else if (rxTick) begin
      s_next.rxCnt = s_reg.rxCnt + 5'h01;
      if (s_reg.rxState == ART_RX_START) begin
        rxSample = (s_reg.rxCnt == ART_MID_START);
      end else begin
        rxSample = (s_reg.rxCnt == ART_BIT_LAST);
      end
    end
    if (rxSample) begin
      s_next.rxCnt = 5'h00;
      case (s_reg.rxState)
        ART_RX_START: begin
          // A glitch shorter than half a bit is not a start bit
          s_next.rxState = line ? ART_RX_IDLE : ART_RX_DATA;
        end
        ART_RX_DATA: begin
          s_next.rxShift[s_reg.rxBit] = line;
          if (s_reg.rxBit != rxLast) begin
            s_next.rxBit = s_reg.rxBit + 3'h1;
          end else if (s_reg.cfg.parDis) begin
            s_next.rxState = ART_RX_STOP;
          end else begin
            s_next.rxState = ART_RX_PARITY;
          end
        end
        ART_RX_PARITY: begin
          s_next.rxPar = line;
          s_next.rxState = ART_RX_STOP;
        end
        default: begin
          // Only the first stop bit is checked; a second is idle time
          rxXfer = 1'b1;
          s_next.rxState = ART_RX_IDLE;
          s_next.rxHold = s_reg.rxShift;
          s_next.pe = !s_reg.cfg.parDis && (s_reg.rxPar != parBit(
                      s_reg.rxShift, s_reg.cfg.lenSel,
                      s_reg.cfg.evenPar));
          s_next.fe = !line;
          s_next.oe = s_reg.dr;
          s_next.dr = 1'b1;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Master clear; configuration and synchronisers are kept
    if (p[ART_S_MCLR]) begin
      txMove = 1'b0;
      rxXfer = 1'b0;
      s_next.txState = ART_TX_IDLE;
      s_next.txCnt = 5'h00;
      s_next.txBit = 3'h0;
      s_next.txShift = 8'h00;
      s_next.txPend = 1'b0;
      s_next.txHoldEmpty = 1'b1;
      s_next.txLine = 1'b1;
      s_next.rxState = ART_RX_IDLE;
      s_next.rxCnt = 5'h00;
      s_next.rxBit = 3'h0;
      s_next.rxShift = 8'h00;
      s_next.rxHold = 8'h00;
      s_next.pe = 1'b0;
      s_next.fe = 1'b0;
      s_next.oe = 1'b0;
      s_next.dr = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= ART_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; enables are high while the pins are driven
  assign rxParallelOut = s_reg.rxHold;
  assign rxParallelOe = !s_reg.sync2[ART_S_RXTRI];
  assign flagsOut = '{parityErr: s_reg.pe, framingErr: s_reg.fe,
                      overrun: s_reg.oe, dataReceived: s_reg.dr,
                      txBufEmpty: s_reg.txHoldEmpty};
  assign flagsOe = !s_reg.sync2[ART_S_FLTRI];
  assign txLineOut = s_reg.txLine;
  assign txShiftEmpty = (s_reg.txState == ART_TX_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  rxOeFollow_a: assert property (@(posedge clk) disable iff (srst)
    $rose(s_reg.sync2[ART_S_RXTRI]) |-> !rxParallelOe
      ##1 (!rxParallelOe || $fell(s_reg.sync2[ART_S_RXTRI])))
    else $error("receive data still driven while tristated");

  flagsOeFollow_a: assert property (@(posedge clk) disable iff (srst)
    s_reg.sync2[ART_S_FLTRI] |-> !flagsOe)
    else $error("status flags driven while tristated");

  upperZero_a: assert property (@(posedge clk) disable iff (srst)
    (rxXfer && s_reg.cfg.lenSel == ART_LEN5) |=> rxParallelOut[7:5] == 3'h0)
    else $error("upper receive bits not low for short character");

  parityClamp_a: assert property (@(posedge clk) disable iff (srst)
    (rxXfer && s_reg.cfg.parDis) |=> !flagsOut.parityErr)
    else $error("parity error raised while parity inhibited");

  overrunSet_a: assert property (@(posedge clk) disable iff (srst)
    (rxXfer && s_reg.dr) |=> flagsOut.overrun && flagsOut.dataReceived)
    else $error("overrun not flagged on unread character");

  drSetWins_a: assert property (@(posedge clk) disable iff (srst)
    rxXfer |=> flagsOut.dataReceived)
    else $error("data received not set on transfer");

  drClear_a: assert property (@(posedge clk) disable iff (srst)
    (!s_reg.sync2[ART_S_DRCLR] && !rxXfer) |=> !flagsOut.dataReceived)
    else $error("data received not cleared by acknowledge");

  masterClear_a: assert property (@(posedge clk) disable iff (srst)
    s_reg.sync2[ART_S_MCLR] |=> txLineOut && txShiftEmpty
      && flagsOut.txBufEmpty && !flagsOut.dataReceived)
    else $error("master clear did not reach reset values");

  startBit_a: assert property (@(posedge clk) disable iff (srst)
    txMove |=> !txLineOut && !txShiftEmpty && flagsOut.txBufEmpty
      ##1 !txLineOut)
    else $error("start bit not sent after transfer");

  loadDefer_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.txPend && s_reg.txState == ART_TX_DATA) |-> !txMove)
    else $error("character moved during a transmission");

endmodule
